/* File: src/gpio_port_defs.vh */
// Constants for the indexed GPIO port block: file addresses, selector codes, reset values.
// Assumes inclusion by the single design file of the block; holds definitions only.
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// Data-memory file addresses of the first and last of the five port data registers.
`define ADDR_PORT_ONE 5'h05
`define ADDR_PORT_FIVE 5'h09

// Selector codes for the control-move operation.
`define SEL_RD_TIMER_LAST 8'h07
`define SEL_XCH_COMPARATOR 8'h08
`define SEL_XCH_WAKE_PEND 8'h09
`define SEL_WR_WAKE_EDGE 8'h0A
`define SEL_WR_WAKE_EN 8'h0B
`define SEL_RD_SCHMITT 8'h0C
`define SEL_RD_THRESHOLD 8'h0D
`define SEL_RD_PULLUP 8'h0E
`define SEL_RD_DIRECTION 8'h0F
`define SEL_CLR_TIMER 8'h10
`define SEL_WR_TIMER_LAST 8'h17
`define SEL_XCH_COMPARATOR_HI 8'h18
`define SEL_XCH_WAKE_PEND_HI 8'h19
`define SEL_WR_WAKE_EDGE_HI 8'h1A
`define SEL_WR_WAKE_EN_HI 8'h1B
`define SEL_WR_SCHMITT 8'h1C
`define SEL_WR_THRESHOLD 8'h1D
`define SEL_WR_PULLUP 8'h1E
`define SEL_WR_DIRECTION 8'h1F

// Position of the write/read bit inside the selector.
`define SEL_WRITE_BIT 4

// Low three bits of a timer code pick the timer register.
`define TMR_CONTROL_B 3'h6

// Position of the read-source select bit in timer two control B.
`define PIN_READ_SELECT_BIT 0

// Reset values.
`define SELECTOR_RESET 8'h1F
`define CONTROL_RESET 8'hFF
`define TIMER_RESET 8'h00
`define TIMER_TWO_CNTB_RESET 8'h01
`define DATA_RESET 8'h00

`endif

/* File: src/indexed_gpio_port.v */
// Five 8-bit GPIO ports with memory-mapped data and selector-indexed control registers.
// Assumes a CPU core on the same clock issues one file access or control-move per cycle.
// Pin levels arrive from outside the clock domain and are synchronised here before use.
// Operation
// - Port data at file addresses 05h to 09h.
// - Data writes drive pins set as outputs.
// - Input pin writes stored, driven when output.
// - Read-select bit picks pins or data register.
// - By default reads return pin levels.
// - Reduced variant: port one has four pins.
// - Selector reachable only by dedicated instructions.
// - Selector picks control register, including timers.
// - Selector resets to direction-write code.
// - Bit four chooses read or write.
// - Comparator and wake-pending always exchange.
// - Wake edge and enable always written.
// - Selector value persists until reloaded.
// - 1Fh writes, 0Fh reads direction registers.
// - Pull-up bit one disconnects, zero connects.
// - Direction one is input, zero output.
// - Port one lacks Schmitt control register.
// - Threshold bit one TTL, zero CMOS.
// - Schmitt bit zero enables, one disables.
// - Control registers other than timers reset to all ones.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defs.vh"

module indexed_gpio_port #(
  parameter REDUCED_PINS = 0
) (
  input wire clk,
  input wire rst_b,
  input wire [4:0] file_addr,
  input wire file_wr,
  input wire [7:0] file_wdata,
  output reg [7:0] file_rdata_q,
  input wire sel_load,
  input wire [7:0] sel_wdata,
  output reg [7:0] sel_rdata_q,
  input wire ctl_move,
  input wire [2:0] ctl_port,
  input wire [7:0] w_in,
  output reg [7:0] w_out_q,
  output reg w_load_q,
  output reg timer_one_clear_q,
  output reg timer_two_clear_q,
  input wire [39:0] pin_in,
  output reg [39:0] pin_out_q,
  output reg [39:0] pin_oe_b_q,
  output reg [39:0] pullup_en_q,
  output reg [39:0] threshold_ttl_q,
  output reg [39:0] schmitt_en_q,
  output reg [7:0] comparator_control_q,
  output reg [7:0] wake_edge_select_q,
  output reg [7:0] wake_enable_bits_q
);

  // Two-stage synchroniser for the pin levels.
  reg [39:0] pin_meta_q;
  reg [39:0] pin_sync_q;
  // Selector register, never visible in data memory.
  reg [7:0] selector_q;
  // Per-port data, direction, pull-up, threshold and Schmitt registers.
  reg [7:0] data_q [0:4];
  reg [7:0] dir_q [0:4];
  reg [7:0] pullup_q [0:4];
  reg [7:0] level_q [0:4];
  reg [7:0] schmitt_q [0:4];
  // Timer register images for ports two and three (timers one and two).
  reg [7:0] timer_reg_q [0:1][0:7];
  // Wake pending flags kept here as a plain exchange register.
  reg [7:0] wake_pending_flags_q;
  // Decoded control-move action.
  reg act_read;
  reg act_write;
  reg act_clear;
  reg [7:0] ctl_rd;
  // Index of the addressed port.
  wire [2:0] p = ctl_port;
  // Port one Schmitt register does not exist.
  wire has_schmitt = (p != 3'h0);
  // Port two and three carry the timers.
  wire is_timer_port = (p == 3'h1) || (p == 3'h2);
  wire tsel = (p == 3'h2);
  // File address decode for the data registers.
  wire file_hit = (file_addr >= `ADDR_PORT_ONE) && (file_addr <= `ADDR_PORT_FIVE);
  // Subtracting five maps addresses 05h..09h onto port indexes zero to four.
  wire [2:0] file_idx = file_addr[2:0] - 3'h5;
  // Timer write codes 12h..17h; codes 1Ch..1Fh belong to the port registers.
  wire timer_code_wr = (selector_q > `SEL_CLR_TIMER) && (selector_q <= `SEL_WR_TIMER_LAST)
                       && (selector_q[2:0] != 3'h1);
  // Read source: pins when the bit in timer two control B is set; reset sets it.
  wire read_pins = timer_reg_q[1][`TMR_CONTROL_B][`PIN_READ_SELECT_BIT];
  // Mask for the reduced variant of port one.
  wire [7:0] port_one_mask = (REDUCED_PINS != 0) ? 8'h0F : 8'hFF;

  // Decodes the selector and port into a read, write or exchange action.
  always @* begin
    act_read = 1'b0;
    act_write = 1'b0;
    act_clear = 1'b0;
    ctl_rd = 8'h00;
    // Ports above five do not exist, so such moves fall through to no action.
    if (ctl_move && p <= 3'h4) begin
      case (selector_q)
        `SEL_XCH_COMPARATOR, `SEL_XCH_COMPARATOR_HI: begin
          // Exchange regardless of the write bit.
          act_read = (p == 3'h1);
          act_write = (p == 3'h1);
          ctl_rd = comparator_control_q;
        end
        `SEL_XCH_WAKE_PEND, `SEL_XCH_WAKE_PEND_HI: begin
          // Exchange of the wake pending flags.
          act_read = (p == 3'h1);
          act_write = (p == 3'h1);
          ctl_rd = wake_pending_flags_q;
        end
        `SEL_WR_WAKE_EDGE, `SEL_WR_WAKE_EDGE_HI, `SEL_WR_WAKE_EN, `SEL_WR_WAKE_EN_HI: begin
          // Always a write, even with the write bit clear.
          act_write = (p == 3'h1);
        end
        `SEL_RD_SCHMITT: begin
          // Port one has no Schmitt register, so the read is refused there.
          act_read = has_schmitt;
          ctl_rd = schmitt_q[p];
        end
        `SEL_RD_THRESHOLD: begin
          // Threshold registers exist on every port.
          act_read = 1'b1;
          ctl_rd = level_q[p];
        end
        `SEL_RD_PULLUP: begin
          // Pull-up registers exist on every port.
          act_read = 1'b1;
          ctl_rd = pullup_q[p];
        end
        `SEL_RD_DIRECTION: begin
          // Direction registers exist on every port.
          act_read = 1'b1;
          ctl_rd = dir_q[p];
        end
        `SEL_CLR_TIMER: begin
          // Only ports two and three own a timer to clear.
          act_clear = is_timer_port;
        end
        `SEL_WR_SCHMITT: begin
          // Schmitt writes aimed at port one are dropped.
          act_write = has_schmitt;
        end
        `SEL_WR_THRESHOLD, `SEL_WR_PULLUP, `SEL_WR_DIRECTION: begin
          // Threshold, pull-up and direction writes reach every port.
          act_write = 1'b1;
        end
        default: begin
          // Timer codes, or nothing at all for unmapped codes.
          if (selector_q <= `SEL_RD_TIMER_LAST) begin
            act_read = is_timer_port;
            ctl_rd = timer_reg_q[tsel][selector_q[2:0]];
          end else if (selector_q > `SEL_CLR_TIMER && selector_q <= `SEL_WR_TIMER_LAST
                       && selector_q[2:0] != 3'h1) begin
            act_write = is_timer_port;
          end
        end
      endcase
    end
  end

  // Synchronises the pins, a plain two-flop chain.
  always @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_q <= 40'h0000000000;
      pin_sync_q <= 40'h0000000000;
    end else begin
      // Only the second flop feeds logic; the first may settle late.
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Selector load and readback; unchanged by control-moves.
  always @(posedge clk) begin
    if (!rst_b) begin
      // Reset selects direction writes so the ports can be set up at once.
      selector_q <= `SELECTOR_RESET;
      sel_rdata_q <= `SELECTOR_RESET;
    end else begin
      if (sel_load) begin
        selector_q <= sel_wdata;
      end
      // Readback takes the value being loaded, so it never lags the selector.
      sel_rdata_q <= sel_load ? sel_wdata : selector_q;
    end
  end

  // Working register return path for reads and exchanges.
  always @(posedge clk) begin
    if (!rst_b) begin
      w_out_q <= 8'h00;
      w_load_q <= 1'b0;
      timer_one_clear_q <= 1'b0;
      timer_two_clear_q <= 1'b0;
    end else begin
      // Only reads and exchanges return a value to the working register.
      w_load_q <= act_read;
      // The returned value holds between reads.
      if (act_read) begin
        w_out_q <= ctl_rd;
      end
      // Clear pulses last one cycle and name the timer of the addressed port.
      timer_one_clear_q <= act_clear && !tsel;
      timer_two_clear_q <= act_clear && tsel;
    end
  end

  // Comparator and wake registers, reached only through port two.
  always @(posedge clk) begin
    if (!rst_b) begin
      comparator_control_q <= `CONTROL_RESET;
      wake_pending_flags_q <= `CONTROL_RESET;
      wake_edge_select_q <= `CONTROL_RESET;
      wake_enable_bits_q <= `CONTROL_RESET;
    end else if (act_write && p == 3'h1) begin
      // The exchange takes W on the same edge that returns the old value.
      if (selector_q == `SEL_XCH_COMPARATOR || selector_q == `SEL_XCH_COMPARATOR_HI) begin
        comparator_control_q <= w_in;
      end
      // Wake pending flags are a plain exchange register here.
      if (selector_q == `SEL_XCH_WAKE_PEND || selector_q == `SEL_XCH_WAKE_PEND_HI) begin
        wake_pending_flags_q <= w_in;
      end
      // Edge select is written whatever the state of bit 4.
      if (selector_q == `SEL_WR_WAKE_EDGE || selector_q == `SEL_WR_WAKE_EDGE_HI) begin
        wake_edge_select_q <= w_in;
      end
      // Wake enables are written whatever the state of bit 4.
      if (selector_q == `SEL_WR_WAKE_EN || selector_q == `SEL_WR_WAKE_EN_HI) begin
        wake_enable_bits_q <= w_in;
      end
    end
  end

  // Timer register images, written by codes 12h to 17h; code 10h only pulses the timer clear outputs.
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_tmr
      integer k;
      always @(posedge clk) begin
        if (!rst_b) begin
          for (k = 0; k < 8; k = k + 1) begin
            timer_reg_q[t][k] <= `TIMER_RESET;
          end
          // Pin-read select starts at one, so reads return pin levels by default.
          if (t == 1) begin
            timer_reg_q[t][`TMR_CONTROL_B] <= `TIMER_TWO_CNTB_RESET;
          end
        end else if (act_write && is_timer_port && tsel == t && timer_code_wr
                     && selector_q[`SEL_WRITE_BIT]) begin
          // Pull-up, direction and other write codes on these ports must not land here.
          timer_reg_q[t][selector_q[2:0]] <= w_in;
        end
      end
    end
  endgenerate

  // Per-port registers and pin drive, one copy per port.
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_port
      wire ctl_here = act_write && (p == g);
      // Only port one can lose pins, on the reduced variant.
      wire [7:0] mask = (g == 0) ? port_one_mask : 8'hFF;
      always @(posedge clk) begin
        if (!rst_b) begin
          // Control registers start at all ones: released TTL inputs, no pull-ups.
          data_q[g] <= `DATA_RESET;
          dir_q[g] <= `CONTROL_RESET;
          pullup_q[g] <= `CONTROL_RESET;
          level_q[g] <= `CONTROL_RESET;
          schmitt_q[g] <= `CONTROL_RESET;
        end else begin
          // Data is stored whatever the direction of the pin.
          if (file_wr && file_hit && file_idx == g) begin
            data_q[g] <= file_wdata;
          end
          // Direction write, code 1Fh.
          if (ctl_here && selector_q == `SEL_WR_DIRECTION) begin
            dir_q[g] <= w_in;
          end
          // Pull-up write, code 1Eh.
          if (ctl_here && selector_q == `SEL_WR_PULLUP) begin
            pullup_q[g] <= w_in;
          end
          // Threshold write, code 1Dh.
          if (ctl_here && selector_q == `SEL_WR_THRESHOLD) begin
            level_q[g] <= w_in;
          end
          // Schmitt write, code 1Ch, absent on port one.
          if (ctl_here && selector_q == `SEL_WR_SCHMITT && g != 0) begin
            schmitt_q[g] <= w_in;
          end
        end
      end
      // Pin outputs follow the registers one cycle later.
      always @(posedge clk) begin
        if (!rst_b) begin
          pin_out_q[8*g+7:8*g] <= 8'h00;
          pin_oe_b_q[8*g+7:8*g] <= 8'hFF;
          pullup_en_q[8*g+7:8*g] <= 8'h00;
          threshold_ttl_q[8*g+7:8*g] <= 8'hFF;
          schmitt_en_q[8*g+7:8*g] <= 8'h00;
        end else begin
          pin_out_q[8*g+7:8*g] <= data_q[g] & mask;
          // A missing pin of port one is never driven.
          pin_oe_b_q[8*g+7:8*g] <= dir_q[g] | ~mask;
          // A pull-up bit of one disconnects, so the enable is its inverse.
          pullup_en_q[8*g+7:8*g] <= ~pullup_q[g];
          threshold_ttl_q[8*g+7:8*g] <= level_q[g];
          // Port one has no Schmitt stage, so its enables stay low.
          schmitt_en_q[8*g+7:8*g] <= (g == 0) ? 8'h00 : ~schmitt_q[g];
        end
      end
    end
  endgenerate

  // File read data: pin levels or stored data.
  always @(posedge clk) begin
    if (!rst_b) begin
      file_rdata_q <= 8'h00;
    end else if (file_hit) begin
      if (read_pins) begin
        // Synchronised pin levels, whatever the direction of each pin.
        file_rdata_q <= pin_sync_q[8*file_idx +: 8];
      end else begin
        // Stored data register contents.
        file_rdata_q <= data_q[file_idx];
      end
    end else begin
      // Unmapped addresses read as zero.
      file_rdata_q <= 8'h00;
    end
  end

endmodule // indexed_gpio_port

`default_nettype wire

/* File: bench/indexed_gpio_port_chk.sv */
// Checker for the indexed GPIO port block; it watches only the top-level ports.
// Assumes one clock domain with a synchronous active-low reset; attached by bind.
`timescale 1ns/10ps
`default_nettype none
module indexed_gpio_port_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] file_addr,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata_q,
  input wire logic sel_load,
  input wire logic [7:0] sel_wdata,
  input wire logic [7:0] sel_rdata_q,
  input wire logic ctl_move,
  input wire logic [2:0] ctl_port,
  input wire logic [7:0] w_in,
  input wire logic [7:0] w_out_q,
  input wire logic w_load_q,
  input wire logic timer_one_clear_q,
  input wire logic [39:0] pin_out_q,
  input wire logic [39:0] pin_oe_b_q,
  input wire logic [7:0] comparator_control_q,
  input wire logic [7:0] wake_edge_select_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A control-move aimed at port two, the only port with wake and comparator registers.
  wire logic mv2 = ctl_move && ctl_port == 3'd1;
  chk_reset_vals: assert property ($rose(rst_b) |-> sel_rdata_q == 8'h1F && comparator_control_q == 8'hFF) else $error("bad reset value");
  chk_sel_load: assert property (sel_load |=> sel_rdata_q == $past(sel_wdata)) else $error("selector not loaded");
  chk_sel_hold: assert property (!sel_load |=> $stable(sel_rdata_q)) else $error("selector moved");
  chk_file_unmapped: assert property (file_addr < 5'h05 || file_addr > 5'h09 |=> file_rdata_q == 8'h00) else $error("unmapped read not zero");
  chk_data_drive: assert property (file_wr && file_addr == 5'h06 |-> ##2 pin_out_q[15:8] == $past(file_wdata, 2)) else $error("pin data wrong");
  chk_dir_write: assert property (mv2 && sel_rdata_q == 8'h1F |-> ##2 pin_oe_b_q[15:8] == $past(w_in, 2)) else $error("direction wrong");
  chk_cmp_swap: assert property (mv2 && (sel_rdata_q == 8'h08 || sel_rdata_q == 8'h18) |=> w_load_q && w_out_q == $past(comparator_control_q) && comparator_control_q == $past(w_in)) else $error("exchange wrong");
  chk_wake_write: assert property (mv2 && (sel_rdata_q == 8'h0A || sel_rdata_q == 8'h1A) |=> !w_load_q && wake_edge_select_q == $past(w_in)) else $error("wake edge write wrong");
  chk_timer_clear: assert property (mv2 && sel_rdata_q == 8'h10 |=> timer_one_clear_q) else $error("no timer clear");
  chk_bad_port: assert property (ctl_move && ctl_port > 3'd4 |=> !w_load_q) else $error("move on absent port");
  chk_wload_cause: assert property (w_load_q |-> $past(ctl_move)) else $error("stray W load");
endmodule // indexed_gpio_port_chk
bind indexed_gpio_port indexed_gpio_port_chk chk (.clk(clk), .rst_b(rst_b), .file_addr(file_addr),
  .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata_q(file_rdata_q), .sel_load(sel_load),
  .sel_wdata(sel_wdata), .sel_rdata_q(sel_rdata_q), .ctl_move(ctl_move), .ctl_port(ctl_port),
  .w_in(w_in), .w_out_q(w_out_q), .w_load_q(w_load_q), .timer_one_clear_q(timer_one_clear_q),
  .pin_out_q(pin_out_q), .pin_oe_b_q(pin_oe_b_q), .comparator_control_q(comparator_control_q),
  .wake_edge_select_q(wake_edge_select_q));
`default_nettype wire

/* File: bench/test_indexed_gpio_port.sv */
// Testbench for the indexed GPIO port block: file accesses and control-moves with expectations.
// Assumes the checker binds itself to the design; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module test_indexed_gpio_port;
  logic clk; // System clock.
  logic rst_b = 1'b0, file_wr = 1'b0, sel_load = 1'b0, ctl_move = 1'b0; // Strobes start idle.
  logic [4:0] file_addr = 5'h00; // File address, unmapped at start.
  logic [7:0] file_wdata = 8'h00, sel_wdata = 8'h00, w_in = 8'h00, wo, v; // Data and captures.
  logic [2:0] ctl_port = 3'h0; // Port addressed by a control-move.
  logic [39:0] pin_in = 40'h12_3456_789A; // Pin levels unlike any stored data.
  logic wl; // Captured W load pulse.
  logic [1:0] tc; // Captured timer clear pulses.
  wire [7:0] frd, srd, w_out_q, cc, we, wk; // Design outputs.
  wire w_load_q, t1, t2; // Design pulses.
  wire [39:0] po, oe, pu, th, st; // Per-pin outputs.
  int error_cnt = 0, checks_done = 0; // Tallies.
  indexed_gpio_port uut (.clk(clk), .rst_b(rst_b), .file_addr(file_addr), .file_wr(file_wr),
    .file_wdata(file_wdata), .file_rdata_q(frd), .sel_load(sel_load), .sel_wdata(sel_wdata),
    .sel_rdata_q(srd), .ctl_move(ctl_move), .ctl_port(ctl_port), .w_in(w_in), .w_out_q(w_out_q),
    .w_load_q(w_load_q), .timer_one_clear_q(t1), .timer_two_clear_q(t2), .pin_in(pin_in),
    .pin_out_q(po), .pin_oe_b_q(oe), .pullup_en_q(pu), .threshold_ttl_q(th), .schmitt_en_q(st),
    .comparator_control_q(cc), .wake_edge_select_q(we), .wake_enable_bits_q(wk));
  // The clock toggles every half period of 5 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Waits n edges and lets their updates settle.
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Loads the selector in one pulse; the bench only loads codes from the defined map.
  task sel(input logic [7:0] s);
    @(posedge clk);
    sel_load <= 1'b1;
    sel_wdata <= s;
    @(posedge clk);
    sel_load <= 1'b0;
  endtask
  // Issues one control-move, captures the W answer, then lets derived outputs settle.
  task mv(input logic [2:0] p, input logic [7:0] w);
    @(posedge clk);
    ctl_move <= 1'b1;
    ctl_port <= p;
    w_in <= w;
    @(posedge clk);
    ctl_move <= 1'b0;
    #1;
    wo = w_out_q;
    wl = w_load_q;
    tc = {t2, t1};
    tick(1);
  endtask
  // Writes one file register; no read of it starts before the write has landed.
  task fw(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    file_wr <= 1'b1;
    file_addr <= a;
    file_wdata <= d;
    @(posedge clk);
    file_wr <= 1'b0;
  endtask
  // Presents a file address; the answer is settled one cycle later.
  task fr(input logic [4:0] a);
    @(posedge clk);
    file_addr <= a;
    tick(1);
  endtask
  // Prints the tallies and the verdict, then ends the run.
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hang short well after the sequence should be over.
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence of accesses.
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    `CHK(srd, 8'h1F)
    `CHK({oe, pu, th, st, cc & we & wk}, {{40{1'b1}}, 40'h0, {40{1'b1}}, 40'h0, 8'hFF})
    for (int k = 0; k < 5; k++) fw(5'h05 + k[4:0], 8'hA0 + k[7:0]);
    for (int k = 0; k < 5; k++) begin
      fr(5'h05 + k[4:0]);
      `CHK(frd, pin_in[8*k+:8])
    end
    sel(8'h16);
    mv(3'd2, 8'h00);
    for (int k = 0; k < 5; k++) begin
      fr(5'h05 + k[4:0]);
      `CHK(frd, 8'hA0 + k[7:0])
    end
    fw(5'h0A, 8'h77);
    fr(5'h0A);
    `CHK(frd, 8'h00)
    fr(5'h04);
    `CHK(frd, 8'h00)
    sel(8'h1F);
    mv(3'd1, 8'h0F);
    `CHK({wl, oe[15:8], po[11:8]}, {1'b0, 8'h0F, 4'h1})
    fw(5'h06, 8'h3C);
    tick(1);
    `CHK(po[11:8], 4'hC)
    sel(8'h0F);
    mv(3'd1, 8'h00);
    `CHK({wl, wo, oe[15:8]}, {1'b1, 8'h0F, 8'h0F})
    sel(8'h1E);
    for (int k = 0; k < 5; k++) begin
      v = {k[3:0], ~k[3:0]};
      mv(k[2:0], v);
      `CHK(pu[8*k+:8], ~v)
    end
    `CHK(srd, 8'h1E)
    sel(8'h1D);
    mv(3'd3, 8'h0F);
    `CHK(th[31:24], 8'h0F)
    sel(8'h1C);
    mv(3'd3, 8'hF0);
    `CHK(st[31:24], 8'h0F)
    mv(3'd0, 8'h00);
    `CHK({wl, st[7:0]}, 9'h000)
    sel(8'h0C);
    mv(3'd3, 8'h00);
    `CHK({wl, wo}, {1'b1, 8'hF0})
    mv(3'd0, 8'h00);
    `CHK(wl, 1'b0)
    sel(8'h18);
    mv(3'd1, 8'h3C);
    `CHK({wl, wo, cc}, {1'b1, 8'hFF, 8'h3C})
    sel(8'h08);
    mv(3'd1, 8'hC3);
    `CHK({wl, wo, cc}, {1'b1, 8'h3C, 8'hC3})
    sel(8'h19);
    mv(3'd1, 8'h5A);
    sel(8'h09);
    mv(3'd1, 8'h00);
    `CHK({wl, wo}, {1'b1, 8'h5A})
    sel(8'h0A);
    mv(3'd1, 8'h55);
    `CHK({wl, we}, {1'b0, 8'h55})
    sel(8'h1B);
    mv(3'd1, 8'h66);
    `CHK({wl, wk}, {1'b0, 8'h66})
    sel(8'h10);
    mv(3'd1, 8'h00);
    `CHK(tc, 2'b01)
    mv(3'd2, 8'h00);
    `CHK(tc, 2'b10)
    mv(3'd5, 8'h12);
    `CHK(wl, 1'b0)
    sel(8'h17);
    mv(3'd1, 8'h77);
    sel(8'h07);
    mv(3'd1, 8'h00);
    `CHK({wl, wo}, {1'b1, 8'h77})
    sel(8'h16);
    mv(3'd2, 8'h01);
    fr(5'h07);
    tick(3);
    `CHK(frd, pin_in[23:16])
    give_verdict();
  end
endmodule // test_indexed_gpio_port
`default_nettype wire
